/* File: sar_pkg.sv */
package sar_pkg;

    // ************************************************************
    // converter geometry and timing
    // ************************************************************
    localparam int          CODE_BITS      = 16;
    localparam int          CLK_MHZ        = 125;
    localparam int          STEP_NS        = 80;   // one bit decision per step
    localparam int          STEP_CYCLES    = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_HIGH_NS = 20;   // least strobe high time
    localparam int          STROBE_HIGH_CYCLES = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] CODE_RESET     = 16'h0000;

    // gain compression scale: 0.8 as 13/16 rounded is not exact, use 0.8 = 0xcccd/0x10000
    localparam logic [16:0] GAIN_NUM       = 17'h0cccd;
    localparam logic [16:0] GAIN_OFFSET    = 17'h01999;  // 0.1 of span, unsigned domain

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic        gain_compression; // high = compressed range
        logic [15:0] sample;           // sampled analog level, offset binary
        logic [15:0] threshold;        // trial level from the cap dac
    } analog_side_t;

    typedef enum logic [3:0] {
        ST_SLEEP   = 4'b0001,
        ST_ACQUIRE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_DONE    = 4'b1000
    } conv_state_t;

endpackage

/* File: sar_link_shift.sv */
`timescale 1ns/1ps
`default_nettype none

// serial shift path on the host serial clock domain
module sar_link_shift
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             sck,
    input  wire logic             resetn,
    input  wire logic             load_toggle,
    input  wire logic [WIDTH-1:0] load_word,
    input  wire logic             chain,
    input  wire logic             read_enable_or_chain_in,
    output logic                  sdo,
    output logic                  sdo_oe
);

    // ************************************************************
    // crossings from the core domain and the chain pin
    // ************************************************************
    logic       tog_meta;
    logic       tog_sync;
    logic       tog_seen;
    logic       chain_meta;
    logic       chain_sync;
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] next_shift;
    logic       next_tog_seen;

    // core word is held stable long before the toggle is seen
    always_comb
    begin
        next_tog_seen = tog_sync;
        if (tog_sync != tog_seen)
            next_shift = load_word;                                    // RULE_10
        else if (chain_sync)
            next_shift = {shift[WIDTH-2:0], read_enable_or_chain_in}; // RULE_16
        else
            next_shift = {shift[WIDTH-2:0], 1'b0};                   // RULE_03
    end

    always_ff @(posedge sck or negedge resetn)
    begin
        if (!resetn)
        begin
            tog_meta   <= 1'b0;
            tog_sync   <= 1'b0;
            tog_seen   <= 1'b0;
            chain_meta <= 1'b0;
            chain_sync <= 1'b0;
            shift      <= '0;
        end
        else
        begin
            tog_meta   <= load_toggle;
            tog_sync   <= tog_meta;
            tog_seen   <= next_tog_seen;
            chain_meta <= chain;
            chain_sync <= chain_meta;
            shift      <= next_shift;
        end
    end

    // ************************************************************
    // output pin
    // ************************************************************
    assign sdo    = shift[WIDTH-1];                                   // RULE_04
    assign sdo_oe = chain_sync | ~read_enable_or_chain_in;           // RULE_01 RULE_02 RULE_17

endmodule // sar_link_shift

`default_nettype wire

/* File: sar_adc_serial_readout.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01: chain low: shared pin enables output
// RULE_02: chain high: shared pin is chain input
// RULE_03: shift result or chain data on sck
// RULE_04: output changes on rising sck, msb first
// RULE_05: strobe rising edge wakes and converts
// RULE_06: busy high during conversion only
// RULE_07: result is 16-bit two's complement
// RULE_08: acquire phase then strobe-started conversion; code never enters ST_ACQUIRE, strobe in sleep goes straight to convert
// RULE_09: resolve one bit per step, msb first
// RULE_10: finished code loaded, no latency
// RULE_11: gain select low rescales to 10-90%
// RULE_12: compressed zero 0.1, full 0.9 reference
// RULE_13: steps timed by internal clock only
// RULE_14: power down after conversion until strobe
// RULE_15: host reads only after busy falls
// RULE_16: chain mode: 16-bit shift, own first
// RULE_17: normal mode, enable off: output released
module sar_adc_serial_readout
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sck,
    input  wire logic        convert_strobe,
    input  wire logic        chain,
    input  wire logic        read_enable_or_chain_in,
    input  wire logic        gain_compress_select,
    input  wire logic [15:0] analog_sample,
    output logic             comparator_sample_hold,
    output logic [15:0]      cap_dac,
    output logic             busy,
    output logic             powered_down,
    output logic [15:0]      result_code,
    output logic             sdo,
    output logic             sdo_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic gsel_meta;
    logic gsel_sync;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            strobe_prev <= 1'b0;
            gsel_meta   <= 1'b1;
            gsel_sync   <= 1'b1;
        end
        else
        begin
            strobe_meta <= convert_strobe;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
            gsel_meta   <= gain_compress_select;
            gsel_sync   <= gsel_meta;
        end
    end

    logic strobe_rise;
    assign strobe_rise = strobe_sync & ~strobe_prev;                   // RULE_05

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    sar_pkg::conv_state_t state;
    sar_pkg::conv_state_t next_state;
    logic [15:0] held;
    logic [15:0] next_held;
    logic [15:0] trial;
    logic [15:0] next_trial;
    logic [4:0]  bit_idx;
    logic [4:0]  next_bit_idx;
    logic [7:0]  step_cnt;
    logic [7:0]  next_step_cnt;
    logic [15:0] code;
    logic [15:0] next_code;
    logic        load_toggle;
    logic        next_load_toggle;
    logic        compress;
    logic        next_compress;

    // gain compression scaling of a finished offset-binary level
    function automatic logic [15:0] scale_code(input logic [15:0] raw, input logic comp);
        logic [33:0] prod;
        logic [16:0] lvl;
        prod = 34'(raw) * 34'(sar_pkg::GAIN_NUM);
        lvl  = 17'(prod[32:16]) + sar_pkg::GAIN_OFFSET;
        if (comp)
            scale_code = lvl[15:0];
        else
            scale_code = raw;
    endfunction

    // compressed mode: invert the mapping so 0.1..0.9 spans full code
    function automatic logic [15:0] expand_code(input logic [15:0] raw);
        logic [16:0] base;
        logic [33:0] prod;
        if (raw <= sar_pkg::GAIN_OFFSET[15:0])
            expand_code = 16'h0000;
        else
        begin
            base = {1'b0, raw} - sar_pkg::GAIN_OFFSET;
            prod = 34'(base) * 34'h14000;                               // 1.25 in q16
            if (prod[33:32] != 2'h0)
                expand_code = 16'hffff;
            else
                expand_code = prod[31:16];
        end
    endfunction

    logic [15:0] compare_level;
    logic        keep_bit;
    assign compare_level = compress ? expand_code(held) : held;        // RULE_11 RULE_12
    assign keep_bit      = compare_level >= trial;                      // RULE_09

    always_comb
    begin
        next_state       = state;
        next_held        = held;
        next_trial       = trial;
        next_bit_idx     = bit_idx;
        next_step_cnt    = step_cnt;
        next_code        = code;
        next_load_toggle = load_toggle;
        next_compress    = compress;
        case (state)
            sar_pkg::ST_SLEEP:
            begin
                if (strobe_rise)                                        // RULE_14
                begin
                    next_held     = analog_sample;
                    next_compress = ~gsel_sync;
                    next_trial    = 16'h8000;
                    next_bit_idx  = 5'(sar_pkg::CODE_BITS - 1);
                    next_step_cnt = '0;
                    next_state    = sar_pkg::ST_CONVERT;                // RULE_05
                end
            end
            sar_pkg::ST_ACQUIRE:
            begin
                if (strobe_rise)                                        // RULE_08
                begin
                    next_held     = analog_sample;
                    next_compress = ~gsel_sync;
                    next_trial    = 16'h8000;
                    next_bit_idx  = 5'(sar_pkg::CODE_BITS - 1);
                    next_step_cnt = '0;
                    next_state    = sar_pkg::ST_CONVERT;
                end
            end
            sar_pkg::ST_CONVERT:
            begin
                if (step_cnt == 8'(sar_pkg::STEP_CYCLES - 1))           // RULE_13
                begin
                    next_step_cnt = '0;
                    if (!keep_bit)
                        next_trial[bit_idx[3:0]] = 1'b0;
                    if (bit_idx == 5'h00)
                    begin
                        next_code  = scale_code(keep_bit ? trial : (trial & ~(16'h0001)), 1'b0) ^ 16'h8000; // RULE_07
                        next_state = sar_pkg::ST_DONE;
                    end
                    else
                    begin
                        next_trial[bit_idx[3:0] - 4'h1] = 1'b1;
                        next_bit_idx = bit_idx - 5'h01;
                    end
                end
                else
                    next_step_cnt = step_cnt + 8'h01;
            end
            sar_pkg::ST_DONE:
            begin
                next_load_toggle = ~load_toggle;                        // RULE_10
                next_state       = sar_pkg::ST_SLEEP;                   // RULE_14
            end
            default:
                next_state = sar_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= sar_pkg::ST_SLEEP;
            held        <= sar_pkg::CODE_RESET;
            trial       <= sar_pkg::CODE_RESET;
            bit_idx     <= '0;
            step_cnt    <= '0;
            code        <= sar_pkg::CODE_RESET;
            load_toggle <= 1'b0;
            compress    <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            held        <= next_held;
            trial       <= next_trial;
            bit_idx     <= next_bit_idx;
            step_cnt    <= next_step_cnt;
            code        <= next_code;
            load_toggle <= next_load_toggle;
            compress    <= next_compress;
        end
    end

    // ************************************************************
    // status outputs
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy                   <= 1'b0;
            powered_down           <= 1'b1;
            comparator_sample_hold <= 1'b0;
            cap_dac                <= '0;
        end
        else
        begin
            busy                   <= (next_state == sar_pkg::ST_CONVERT) ||
                                      (next_state == sar_pkg::ST_DONE);  // RULE_06
            powered_down           <= (next_state == sar_pkg::ST_SLEEP); // RULE_14
            comparator_sample_hold <= (next_state == sar_pkg::ST_CONVERT);
            cap_dac                <= next_trial;
        end
    end

    assign result_code = code;

    // ************************************************************
    // serial path on the host clock
    // ************************************************************
    sar_link_shift
    #(
        .WIDTH (sar_pkg::CODE_BITS)
    )
    u_shift
    (
        .sck                     (sck),
        .resetn                  (resetn),
        .load_toggle             (load_toggle),
        .load_word               (code),
        .chain                   (chain),
        .read_enable_or_chain_in (read_enable_or_chain_in),
        .sdo                     (sdo),
        .sdo_oe                  (sdo_oe)
    );

endmodule // sar_adc_serial_readout

`default_nettype wire

/* File: sar_readout_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// readout checker
// ********************
module sar_readout_monitor
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        sck,
    input wire logic        convert_strobe,
    input wire logic        chain,
    input wire logic        read_enable_or_chain_in,
    input wire logic        gain_compress_select,
    input wire logic [15:0] analog_sample,
    input wire logic        comparator_sample_hold,
    input wire logic [15:0] cap_dac,
    input wire logic        busy,
    input wire logic        powered_down,
    input wire logic [15:0] result_code,
    input wire logic        sdo_oe
);
    logic [8:0] busy_len;
    logic [2:0] quiet;
    // busy length and strobe quiet counters
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_len <= 9'h000;
            quiet    <= 3'h0;
        end
        else
        begin
            busy_len <= busy ? busy_len + 9'h001 : 9'h000;
            quiet    <= convert_strobe ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
        end
    end
    property p_busy_rise;
        @(posedge clk) disable iff (!resetn) $rose(convert_strobe) && powered_down |-> ##[1:5] busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy late after strobe");
    property p_busy_len;
        @(posedge clk) disable iff (!resetn) $fell(busy) |-> busy_len == (sar_pkg::CODE_BITS * sar_pkg::STEP_CYCLES + 1);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_result_hold;
        @(posedge clk) disable iff (!resetn) !$stable(result_code) |=> $fell(busy);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved off busy fall");
    property p_sleep_hold;
        @(posedge clk) disable iff (!resetn) powered_down && quiet == 3'h7 |=> powered_down;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("woke without strobe");
    property p_result_value;
        @(posedge clk) disable iff (!resetn)
            $fell(busy) && gain_compress_select |=> result_code == (analog_sample ^ 16'h8000);
    endproperty
    a_result_value: assert property (p_result_value) else $error("result code wrong");
    property p_gain_low_end;
        @(posedge clk) disable iff (!resetn)
            $fell(busy) && !gain_compress_select && analog_sample == 16'h0000 |=> result_code == 16'h8000;
    endproperty
    a_gain_low_end: assert property (p_gain_low_end) else $error("compressed low end wrong");
    property p_oe_normal;
        @(posedge sck) disable iff (!resetn) (!chain)[*3] |-> sdo_oe == !read_enable_or_chain_in;
    endproperty
    a_oe_normal: assert property (p_oe_normal) else $error("output enable wrong");
    property p_oe_chain;
        @(posedge sck) disable iff (!resetn) chain[*3] |-> sdo_oe;
    endproperty
    a_oe_chain: assert property (p_oe_chain) else $error("chain output not driven");
    property p_hold_phase;
        @(posedge clk) disable iff (!resetn) comparator_sample_hold |-> busy;
    endproperty
    a_hold_phase: assert property (p_hold_phase) else $error("hold outside conversion");
    property p_dac_final;
        @(posedge clk) disable iff (!resetn) $fell(busy) && gain_compress_select |-> cap_dac == analog_sample;
    endproperty
    a_dac_final: assert property (p_dac_final) else $error("final trial word wrong");
endmodule // sar_readout_monitor
bind sar_adc_serial_readout sar_readout_monitor i_mon (.clk, .resetn, .sck, .convert_strobe, .chain,
    .read_enable_or_chain_in, .gain_compress_select, .analog_sample, .comparator_sample_hold, .cap_dac,
    .busy, .powered_down, .result_code, .sdo_oe);
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// host: strobe and serial clock
// ********************
module host_model
(
    input  wire logic clk,
    input  wire logic busy,
    input  wire logic chain,
    input  wire logic sdo,
    output logic      convert_strobe,
    output logic      sck,
    output logic      read_enable_or_chain_in
);
    // idle levels, clock stands still
    initial
    begin
        convert_strobe = 1'b0;
        sck = 1'b0;
        read_enable_or_chain_in = 1'b1;
    end
    // strobe, count busy cycles, optional stray strobe
    task automatic convert(input bit again, output int hi);
        int n;
        hi = 0;
        @(negedge clk) convert_strobe = 1'b1;
        repeat (3) @(negedge clk);
        convert_strobe = 1'b0;
        // busy is already up here, so count before each wait
        for (n = 0; n < 400 && !(hi > 0 && !busy); n++)
        begin
            if (busy) hi++;
            if (again && n >= 40 && n < 45) convert_strobe = (n < 44);
            @(negedge clk);
        end
    endtask
    // 34 rises, upstream word fed in chain mode
    task automatic read_frame(input logic [15:0] up, output logic [31:0] seen);
        int i;
        seen = 32'h0;
        if (!chain) read_enable_or_chain_in = 1'b0;
        #5;
        for (i = 0; i < 34; i++)
        begin
            sck = 1'b1;
            #6;
            if (i >= 2) seen = {seen[30:0], sdo};
            sck = 1'b0;
            if (chain) read_enable_or_chain_in = (i >= 2 && i < 18) ? up[17-i] : i[0];
            #6;
        end
        if (!chain) read_enable_or_chain_in = 1'b1;
    endtask
endmodule // host_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// readout testbench
// ********************
module tb_top;
    logic        clk;
    logic        resetn;
    logic        chain;
    logic        gain_compress_select;
    logic [15:0] analog_sample;
    logic        convert_strobe;
    logic        sck;
    logic        read_enable_or_chain_in;
    logic        busy;
    logic        powered_down;
    logic [15:0] result_code;
    logic        sdo;
    logic        sdo_oe;
    logic [31:0] seen;
    int          hi;
    int          fails;
    int          num_checks;
    int          cycles;
    sar_adc_serial_readout i_dut (.clk, .resetn, .sck, .convert_strobe, .chain, .read_enable_or_chain_in,
        .gain_compress_select, .analog_sample, .comparator_sample_hold(), .cap_dac(), .busy, .powered_down,
        .result_code, .sdo, .sdo_oe);
    host_model i_host (.clk, .busy, .chain, .sdo, .convert_strobe, .sck, .read_enable_or_chain_in);
    // core clock and hang limit
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // normal mode words, zeros after, sleep and release
    task automatic t_normal();
        logic [15:0] tab [4];
        int k;
        tab = '{16'h0000, 16'hffff, 16'h8000, 16'h5a3c};
        for (k = 0; k < 4; k++)
        begin
            @(negedge clk) analog_sample = tab[k];
            i_host.convert(1'b0, hi);
            i_host.read_frame(16'h0000, seen);
            @(negedge clk);
            check(seen, {tab[k] ^ 16'h8000, 16'h0000}, "normal word");
            check(32'(powered_down), 32'h1, "asleep");
            check(32'(sdo_oe), 32'h0, "released");
        end
        $display("normal test done");
    endtask
    // compressed range ends saturate; every word is clocked out, as the load crossing is a toggle
    task automatic t_gain();
        @(negedge clk) gain_compress_select = 1'b0;
        analog_sample = 16'h0000;
        repeat (4) @(negedge clk);
        i_host.convert(1'b0, hi);
        check(32'(result_code), 32'h8000, "low end");
        i_host.read_frame(16'h0000, seen);
        check(seen, 32'h8000_0000, "low end word");
        @(negedge clk) analog_sample = 16'hffff;
        i_host.convert(1'b0, hi);
        check(32'(result_code), 32'h7fff, "high end");
        i_host.read_frame(16'h0000, seen);
        check(seen, 32'h7fff_0000, "high end word");
        @(negedge clk) gain_compress_select = 1'b1;
        repeat (4) @(negedge clk);
        $display("gain test done");
    endtask
    // stray strobe mid conversion is ignored
    task automatic t_busy();
        @(negedge clk) analog_sample = 16'h1234;
        i_host.convert(1'b1, hi);
        check(32'(hi), 32'(sar_pkg::CODE_BITS * sar_pkg::STEP_CYCLES + 1), "busy length");
        check(32'(result_code), 32'h9234, "stray strobe");
        i_host.read_frame(16'h0000, seen);
        check(seen, 32'h9234_0000, "busy word");
        $display("busy test done");
    endtask
    // chain mode: own word then upstream word
    task automatic t_chain();
        @(negedge clk) chain = 1'b1;
        analog_sample = 16'h0f3c;
        i_host.convert(1'b0, hi);
        i_host.read_frame(16'hb00d, seen);
        check(seen, {16'h8f3c, 16'hb00d}, "chain word");
        check(32'(sdo_oe), 32'h1, "chain drive");
        $display("chain test done");
    endtask
    // reset then scenarios
    initial
    begin
        resetn = 1'b0;
        chain = 1'b0;
        gain_compress_select = 1'b1;
        analog_sample = 16'h0000;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_normal();
        t_gain();
        t_busy();
        t_chain();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
